// ==== core/ddslc_sync2.sv ====
// two flip-flop level synchroniser, parameterised width
// assumes the destination clock samples an unrelated source
`timescale 1ns/1ps
module ddslc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  // -------------------------------------------------------------
  // two stage capture
  // -------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL; // idle level of the pin, no false edge after reset
      o_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule // ddslc_sync2

// ==== core/ddslc_top.sv ====
// serial write and load control of a dual 16-bit converter
// assumes host drives sync, data and load strobe; serial clock is its own domain
// Overview of operation
// RULE_01: host holds frame sync low for a whole transfer; bits taken meanwhile.
// RULE_02: each input bit shifts in on a falling serial clock edge.
// RULE_03: host keeps data stable and valid at each falling serial clock edge.
// RULE_04: serial register contents drive out on serial data output, one bit per clock.
// RULE_05: falling edge of clear input zeroes both converter registers.
// RULE_06: load strobe low updates addressed converter when frame sync rises.
// RULE_07: load strobe high during frame updates input register only, deferring output.
// RULE_08: one load strobe falling edge updates both converters together.
// RULE_09: board always drives load strobe to a defined level.
// RULE_10: a frame is 24 falling edges; sync rises after the 24th.
// RULE_11: reset clamp low zeros outputs while register contents stay.
// RULE_12: most significant bit first; last 24 bits form the command word.
`timescale 1ns/1ps
`include "ddslc_consts.svh"
module ddslc_top
  import ddslc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_serial_data_in,
  input wire logic i_load_converter_n,
  input wire logic i_async_zero_n,
  input wire logic i_reset_clamp_in_n,
  output logic o_serial_data_out,
  output logic [`DDSLC_DATA_BITS-1:0] o_conv_a,
  output logic [`DDSLC_DATA_BITS-1:0] o_conv_b,
  output logic o_clamp
);
  // -------------------------------------------------------------
  // serial clock domain: shift register and frame capture
  // -------------------------------------------------------------
  ddslc_word_t shift_q;
  ddslc_word_t frame_q;
  logic [4:0] cnt_q;
  logic frame_tgl_q;
  logic sdo_q;

  // shift in on falling edge while sync low, msb first
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_q <= '0;
    end else if (!i_sync_n) begin
      shift_q <= {shift_q[`DDSLC_FRAME_BITS-2:0], i_serial_data_in}; // RULE_02 RULE_12
    end
  end

  // bit counter, cleared while sync is high; the serial clock is parked between frames
  always_ff @(negedge i_sclk or posedge i_sync_n or negedge i_rst_n) begin
    if (!i_rst_n || i_sync_n) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
    end
  end

  // data out changes on rising edge, msb of serial register
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= shift_q[`DDSLC_FRAME_BITS-1]; // RULE_04
    end
  end

  // sync rising edge after at least 24 bits latches the word and flags the core domain
  always_ff @(posedge i_sync_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_q <= '0;
      frame_tgl_q <= 1'b0;
    end else if (cnt_q >= 5'(`DDSLC_FRAME_BITS)) begin // RULE_10
      frame_q <= shift_q; // RULE_12
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // elaboration check: core clock must be at least twice the maximum serial clock
  if (`DDSLC_CLK_MHZ < 2 * `DDSLC_SCLK_MAX_MHZ) begin : g_clk_chk
    $error("core clock too slow for the serial clock");
  end

  // -------------------------------------------------------------
  // crossings into the core clock domain
  // -------------------------------------------------------------
  logic [3:0] pin_s;
  logic tgl_s;
  ddslc_word_t frame_s1_q;
  ddslc_word_t frame_s2_q;

  ddslc_sync2 #(.W(4), .RST_VAL(4'hF)) u_pins (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_load_converter_n, i_async_zero_n, i_reset_clamp_in_n, i_sync_n}),
    .o_q(pin_s)
  );
  ddslc_sync2 #(.W(1)) u_tgl (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(frame_tgl_q),
    .o_q(tgl_s)
  );

  // word changes on the same sync edge as the toggle; copied through two stages every core clock, the same depth as the toggle
  always_ff @(posedge i_clk) begin
    frame_s1_q <= frame_q;
    frame_s2_q <= frame_s1_q;
  end

  // -------------------------------------------------------------
  // edge detection in the core domain
  // -------------------------------------------------------------
  logic load_converter_n_q, clr_q, tgl_q, clamp_q, sdo_s1_q;
  logic ld_n_s, clr_n_s, rst_n_s;
  logic ld_fall, clr_fall, frame_evt;
  assign ld_n_s = pin_s[3];
  assign clr_n_s = pin_s[2];
  assign rst_n_s = pin_s[1];
  assign ld_fall = load_converter_n_q & ~ld_n_s;
  assign clr_fall = clr_q & ~clr_n_s;
  assign frame_evt = tgl_q ^ tgl_s;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      load_converter_n_q <= 1'b1;
      clr_q <= 1'b1;
      tgl_q <= 1'b0;
    end else begin
      load_converter_n_q <= ld_n_s;
      clr_q <= clr_n_s;
      tgl_q <= tgl_s;
    end
  end

  // -------------------------------------------------------------
  // input and converter registers
  // -------------------------------------------------------------
  ddslc_cmd_s cmd;
  logic sel_b;
  logic [`DDSLC_DATA_BITS-1:0] in_a_q, in_b_q, conv_a_q, conv_b_q;
  logic [`DDSLC_DATA_BITS-1:0] conv_a_d, conv_b_d;
  logic wr_a, wr_b, direct;
  assign cmd = ddslc_cmd_s'(frame_s2_q);
  assign sel_b = cmd.addr[0];
  assign wr_a = frame_evt & ~sel_b;
  assign wr_b = frame_evt & sel_b;
  assign direct = ~ld_n_s; // RULE_06 strobe held low loads at sync rise

  // next converter values: clear beats load, load strobe edge moves both
  always_comb begin
    conv_a_d = conv_a_q;
    conv_b_d = conv_b_q;
    if (ld_fall) begin
      conv_a_d = in_a_q; // RULE_08
      conv_b_d = in_b_q; // RULE_08
    end
    if (direct && wr_a) begin
      conv_a_d = cmd.data; // RULE_06
    end
    if (direct && wr_b) begin
      conv_b_d = cmd.data; // RULE_06
    end
    if (clr_fall) begin
      conv_a_d = `DDSLC_CONV_RESET; // RULE_05
      conv_b_d = `DDSLC_CONV_RESET; // RULE_05
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_a_q <= `DDSLC_CONV_RESET;
      in_b_q <= `DDSLC_CONV_RESET;
      conv_a_q <= `DDSLC_CONV_RESET;
      conv_b_q <= `DDSLC_CONV_RESET;
    end else begin
      if (wr_a) in_a_q <= cmd.data; // RULE_07
      if (wr_b) in_b_q <= cmd.data; // RULE_07
      conv_a_q <= conv_a_d;
      conv_b_q <= conv_b_d;
    end
  end

  // -------------------------------------------------------------
  // output clamp: registers keep contents, converter outputs forced to zero
  // -------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clamp_q <= 1'b0;
      o_conv_a <= `DDSLC_CONV_RESET;
      o_conv_b <= `DDSLC_CONV_RESET;
      sdo_s1_q <= 1'b0;
      o_serial_data_out <= 1'b0;
    end else begin
      clamp_q <= ~rst_n_s; // RULE_11
      o_conv_a <= rst_n_s ? conv_a_q : `DDSLC_CONV_RESET; // RULE_11
      o_conv_b <= rst_n_s ? conv_b_q : `DDSLC_CONV_RESET; // RULE_11
      sdo_s1_q <= sdo_q;
      o_serial_data_out <= sdo_s1_q; // RULE_04
    end
  end
  assign o_clamp = clamp_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_clear_zeroes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_fall |=> (conv_a_q == 16'h0000 && conv_b_q == 16'h0000)) // RULE_05
    else $error("clear did not zero converters");
  a_clamp_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rst_n_s |=> (o_conv_a == 16'h0000 && o_clamp)) // RULE_11
    else $error("outputs not clamped");
  a_clamp_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!rst_n_s && !clr_fall && !ld_fall && !frame_evt) |=> $stable(conv_a_q)) // RULE_11
    else $error("clamp changed register");
  a_defer_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ld_n_s && wr_a && !clr_fall) |=> $stable(conv_a_q) && in_a_q == $past(cmd.data)) // RULE_07
    else $error("deferred write touched converter");
  a_both_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ld_fall && !clr_fall && !frame_evt) |=> conv_a_q == $past(in_a_q)
      && conv_b_q == $past(in_b_q)) // RULE_08
    else $error("simultaneous load failed");
  a_direct_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (direct && wr_b && !clr_fall) |=> conv_b_q == $past(cmd.data)) // RULE_06
    else $error("direct load failed");
  a_sdo_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |-> ##2 o_serial_data_out == $past(sdo_q, 2)) // RULE_04
    else $error("serial out path broken");
  a_shift_msb: assert property (@(negedge i_sclk)
    !i_sync_n |=> shift_q[0] == $past(i_serial_data_in)) // RULE_02
    else $error("shift failed");
  a_frame_len: assert property (@(posedge i_sync_n)
    cnt_q >= 5'd24 |=> frame_q == $past(shift_q)) // RULE_10
    else $error("frame not captured");
  c_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n) frame_evt);
  c_load_converter_n: cover property (@(posedge i_clk) disable iff (!i_rst_n) ld_fall);
  c_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) clr_fall);
endmodule // ddslc_top

// ==== include/ddslc_consts.svh ====
// timing counts and reset values for the dual converter serial load block
// assumes inclusion by bare name from the package and design files
`ifndef DDSLC_CONSTS_SVH
`define DDSLC_CONSTS_SVH
`define DDSLC_FRAME_BITS 24
`define DDSLC_DATA_BITS 16
`define DDSLC_ADDR_LSB 16
`define DDSLC_CONV_RESET 16'h0000
`define DDSLC_SCLK_MAX_MHZ 30
`define DDSLC_CLK_MHZ 125
`endif

// ==== include/ddslc_pkg.sv ====
// types shared by the dual converter serial load block
// assumes ddslc_consts.svh on the include path
`include "ddslc_consts.svh"
package ddslc_pkg;
  typedef logic [`DDSLC_FRAME_BITS-1:0] ddslc_word_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [`DDSLC_DATA_BITS-1:0] data;
  } ddslc_cmd_s;
  typedef enum logic [1:0] {DDSLC_IDLE, DDSLC_LOAD} ddslc_state_e;
endpackage

// ==== verification/ddslc_host_model.sv ====
// host side serial model: frames words onto the converter serial port
// assumes the bench calls xfer from its own thread; sclk parks high
`timescale 1ns/1ps
module ddslc_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_serial_data_in,
  input wire logic i_serial_data_out
);
  // idle levels: sync high, clock parked outside frames
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_serial_data_in = 1'b0;
  end
  // one frame of n bits, msb first, reading back the serial output
  task automatic xfer(input logic [47:0] bits, input int n, output logic [47:0] rb);
    rb = '0;
    #37 o_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_in = bits[i];
      #80 rb = {rb[46:0], i_serial_data_out};
      o_sclk = 1'b0;
      #80 o_sclk = 1'b1;
    end
    #40 o_sync_n = 1'b1;
    o_serial_data_in = ~o_serial_data_in; // released line shows no stale bit
    #200;
  endtask
endmodule // ddslc_host_model

// ==== verification/ddslc_top_tb_top.sv ====
// bench for the dual converter serial load block
// assumes ddslc_host_model drives the serial port in its own clock
`timescale 1ns/1ps
module ddslc_top_tb_top;
  logic clk, rst_n, load_n, zero_n, clamp_n, sclk, sync_n, sdi, serial_data_out, clamp;
  logic [15:0] conv_a, conv_b;
  logic [47:0] rb;
  int error_cnt = 0;
  int checks_done = 0;
  // ----------------------------------------
  // design and host model
  // ----------------------------------------
  ddslc_top u_ddslc_top (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_sync_n(sync_n),
    .i_serial_data_in(sdi), .i_load_converter_n(load_n), .i_async_zero_n(zero_n),
    .i_reset_clamp_in_n(clamp_n), .o_serial_data_out(serial_data_out), .o_conv_a(conv_a),
    .o_conv_b(conv_b), .o_clamp(clamp));
  ddslc_host_model u_ddslc_host_model (.o_sclk(sclk), .o_sync_n(sync_n),
    .o_serial_data_in(sdi), .i_serial_data_out(serial_data_out));
  // core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // long frame of two words: only the last one counts, first one reads back
  task automatic t_direct();
    u_ddslc_host_model.xfer(48'h001234015678, 48, rb);
    waitn(12);
    chk("readback", rb[15:0], 16'h1234);
    chk("conv_b direct", conv_b, 16'h5678);
    chk("conv_a kept", conv_a, 16'h0000);
    u_ddslc_host_model.xfer(48'h000000001234, 24, rb);
    waitn(12);
    chk("conv_a direct", conv_a, 16'h1234);
  endtask
  // strobe high: writes wait for one falling edge that moves both
  task automatic t_deferred();
    load_n = 1'b1;
    waitn(5);
    u_ddslc_host_model.xfer(48'h00000000AAAA, 24, rb);
    u_ddslc_host_model.xfer(48'h000000015555, 24, rb);
    waitn(12);
    chk("conv_a held", conv_a, 16'h1234);
    chk("conv_b held", conv_b, 16'h5678);
    load_n = 1'b0;
    waitn(10);
    chk("conv_a loaded", conv_a, 16'hAAAA);
    chk("conv_b loaded", conv_b, 16'h5555);
  endtask
  // clamp zeroes conv_a and raises the flag, values return once released
  task automatic t_clamp();
    u_ddslc_host_model.xfer(48'h000000000F0F, 24, rb);
    waitn(12);
    clamp_n = 1'b0;
    waitn(8);
    chk("conv_a clamped", conv_a, 16'h0000);
    chk("clamp flag", {15'h0000, clamp}, 16'h0001);
    clamp_n = 1'b1;
    waitn(8);
    chk("conv_a kept", conv_a, 16'h0F0F);
    chk("conv_b kept", conv_b, 16'h5555);
  endtask
  // clear edge zeroes both converters
  task automatic t_clear();
    zero_n = 1'b0;
    waitn(8);
    chk("conv_a clear", conv_a, 16'h0000);
    chk("conv_b clear", conv_b, 16'h0000);
    zero_n = 1'b1;
    waitn(4);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b1;
    #1;
    rst_n = 1'b0;
    load_n = 1'b0;
    zero_n = 1'b1;
    clamp_n = 1'b1;
    waitn(4);
    rst_n = 1'b1;
    waitn(4);
    t_direct();
    t_deferred();
    t_clamp();
    t_clear();
    wrap_up();
  end
  // watchdog well beyond the expected 25 us
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule // ddslc_top_tb_top
